// File: core/dsp_pkg.sv
// shared constants, types and register map for the ddr subsystem axi port
package dsp_pkg;
    // configuration
    localparam int DSP_DATA_W = 64;
    localparam int DSP_STRB_W = DSP_DATA_W / 8;
    localparam int DSP_ID_W = 4;
    localparam bit DSP_IS_AXI4 = 1'b1;
    localparam int DSP_LEN_W = DSP_IS_AXI4 ? 8 : 4;
    localparam int DSP_ADDR_W = 32;
    localparam int DSP_MEM_WORDS = 64;
    localparam int DSP_MEM_AW = 6;
    // pll lock and init timing in user clock cycles
    localparam int DSP_LOCK_CYCLES = 16;
    localparam int DSP_INIT_CYCLES = 32;
    // axi encodings
    localparam logic [1:0] DSP_BURST_FIXED = 2'h0;
    localparam logic [1:0] DSP_BURST_INCR = 2'h1;
    localparam logic [1:0] DSP_BURST_WRAP = 2'h2;
    localparam logic [1:0] DSP_RESP_OKAY = 2'h0;
    // host apb register map
    localparam logic [7:0] DSP_REG_CTRL = 8'h00;
    localparam logic [7:0] DSP_REG_ADDR = 8'h04;
    localparam logic [7:0] DSP_REG_WDATA = 8'h08;
    localparam logic [7:0] DSP_REG_RDATA = 8'h0c;
    localparam logic [7:0] DSP_REG_STATUS = 8'h10;
    localparam logic [7:0] DSP_REG_IRQ = 8'h14;
    localparam logic [7:0] DSP_REG_MASK = 8'h18;
    localparam logic [7:0] DSP_REG_LEN = 8'h1c;
    // ctrl bits
    localparam int DSP_CTRL_GO = 0;
    localparam int DSP_CTRL_WRITE = 1;
    localparam int DSP_CTRL_REINIT = 2;
    localparam int DSP_CTRL_CHECK = 3;
    // irq bits
    localparam int DSP_IRQ_DONE = 0;
    localparam int DSP_IRQ_ALERT = 1;
    localparam int DSP_IRQ_READY = 2;
    localparam logic [31:0] DSP_RESET_WORD = 32'h0;
    typedef enum logic [1:0] {
        DSP_R_IDLE = 2'b00,
        DSP_R_BURST = 2'b01,
        DSP_R_RESP = 2'b10
    } dsp_state_t;
    // next beat address: fixed, incrementing or wrapping
    function automatic logic [31:0] dsp_next_addr(input logic [31:0] a, input logic [2:0] sz,
        input logic [1:0] bt, input logic [7:0] len);
        logic [31:0] step;
        logic [31:0] wmask;
        step = 32'h1 << sz;
        wmask = ({24'h0, len} + 32'h1) * step - 32'h1;
        if (bt == DSP_BURST_FIXED)
            dsp_next_addr = a;
        else if (bt == DSP_BURST_WRAP)
            dsp_next_addr = (a & ~wmask) | ((a + step) & wmask);
        else
            dsp_next_addr = a + step;
    endfunction
endpackage

// File: core/dsp_axi_if.sv
// axi slave port plus generic subsystem signals joining the two ends
`timescale 1ns/100ps
interface dsp_axi_if;
    import dsp_pkg::*;
    logic user_logic_clock;
    logic subsystem_async_reset_n;
    logic pll_lock;
    logic controller_ready;
    logic reinit_request;
    logic ca_parity_alert_status;
    logic ca_parity_status_read;
    logic [DSP_ID_W-1:0] awid;
    logic [DSP_ADDR_W-1:0] awaddr;
    logic [DSP_LEN_W-1:0] awlen;
    logic [2:0] awsize;
    logic [1:0] awburst;
    logic [1:0] awlock;
    logic [3:0] awcache;
    logic [2:0] awprot;
    logic awvalid;
    logic awready;
    logic [DSP_ID_W-1:0] wid;
    logic [DSP_DATA_W-1:0] wdata;
    logic [DSP_STRB_W-1:0] wstrb;
    logic wlast;
    logic wvalid;
    logic wready;
    logic [DSP_ID_W-1:0] bid;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [DSP_ID_W-1:0] arid;
    logic [DSP_ADDR_W-1:0] araddr;
    logic [DSP_LEN_W-1:0] arlen;
    logic [2:0] arsize;
    logic [1:0] arburst;
    logic [1:0] arlock;
    logic [3:0] arcache;
    logic [2:0] arprot;
    logic arvalid;
    logic arready;
    logic [DSP_ID_W-1:0] rid;
    logic [DSP_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rlast;
    logic rvalid;
    logic rready;
    modport subsystem (
        output user_logic_clock, pll_lock, controller_ready, ca_parity_alert_status,
        input subsystem_async_reset_n, reinit_request, ca_parity_status_read,
        input awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awvalid,
        output awready,
        input wid, wdata, wstrb, wlast, wvalid,
        output wready, bid, bresp, bvalid,
        input bready,
        input arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arvalid,
        output arready, rid, rdata, rresp, rlast, rvalid,
        input rready
    );
    modport master (
        input user_logic_clock, pll_lock, controller_ready, ca_parity_alert_status,
        output subsystem_async_reset_n, reinit_request, ca_parity_status_read,
        output awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awvalid,
        input awready,
        output wid, wdata, wstrb, wlast, wvalid,
        input wready, bid, bresp, bvalid,
        output bready,
        output arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arvalid,
        input arready, rid, rdata, rresp, rlast, rvalid,
        output rready
    );
endinterface

// File: core/dsp_burst_engine.sv
// one axi burst channel: takes an address, walks the beats, then answers
`timescale 1ns/100ps
module dsp_burst_engine
    import dsp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    // address request
    input wire logic avalid,
    output logic aready,
    input wire logic [DSP_ID_W-1:0] aid,
    input wire logic [DSP_ADDR_W-1:0] aaddr,
    input wire logic [DSP_LEN_W-1:0] alen,
    input wire logic [2:0] asize,
    input wire logic [1:0] aburst,
    // beat handshake
    input wire logic beat_fire,
    output logic in_burst,
    output logic [DSP_ADDR_W-1:0] beat_addr,
    output logic last_beat,
    output logic [DSP_ID_W-1:0] burst_id,
    // final response
    output logic resp_pending,
    input wire logic resp_fire
);
    import dsp_pkg::*;
    dsp_state_t state_reg;
    dsp_state_t state_next;
    logic [7:0] len_reg;
    logic [7:0] cnt_reg;
    logic [2:0] size_reg;
    logic [1:0] burst_reg;
    logic [DSP_ADDR_W-1:0] addr_reg;
    logic [DSP_ID_W-1:0] id_reg;
    wire take = avalid && aready;
    wire last_w = (cnt_reg == len_reg);
    wire [31:0] next_addr_w = dsp_next_addr(addr_reg, size_reg, burst_reg, len_reg);

    // handshake and view of the current beat
    assign aready = enable && (state_reg == DSP_R_IDLE);
    assign in_burst = (state_reg == DSP_R_BURST);
    assign beat_addr = addr_reg;
    assign last_beat = last_w;
    assign burst_id = id_reg;
    assign resp_pending = (state_reg == DSP_R_RESP);

    // next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            DSP_R_IDLE: if (take) state_next = DSP_R_BURST;
            DSP_R_BURST: if (beat_fire && last_w) state_next = DSP_R_RESP;
            DSP_R_RESP: if (resp_fire) state_next = DSP_R_IDLE;
            default: state_next = DSP_R_IDLE;
        endcase
    end

    // burst bookkeeping; any size, type and length is walked
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= DSP_R_IDLE;
            len_reg <= 8'h0;
            cnt_reg <= 8'h0;
            size_reg <= 3'h0;
            burst_reg <= 2'h0;
            addr_reg <= 32'h0;
            id_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (take)
            begin
                len_reg <= 8'(alen); // RQ9
                cnt_reg <= 8'h0;
                size_reg <= asize;
                burst_reg <= aburst;
                addr_reg <= aaddr;
                id_reg <= aid;
            end
            else if (beat_fire && in_burst)
            begin
                cnt_reg <= cnt_reg + 8'h1;
                addr_reg <= next_addr_w; // RQ10
            end
        end
    end
endmodule

// File: core/dsp_subsystem.sv
// device end: clock, lock, ready, alert status and axi slave onto a memory
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
// How it works
// [RQ1] axi slave mode carries all memory traffic
// [RQ2] native logic runs on the user clock
// [RQ3] user clock forwarded from pll output
// [RQ4] reset is init-done and bank-calibrated
// [RQ5] lock rises once pll has locked
// [RQ6] ready low in reset and reinit
// [RQ7] parity status set on seen alert
// [RQ8] parity status clears on read
// [RQ9] every burst size, type, length accepted
// [RQ10] wrapping bursts wrap at their boundary
// [RQ11] data width parameter, strobe one eighth
// [RQ12] axi signals active high, user clock
// [RQ13] length field eight or four bits
// [RQ14] lock, cache, prot inputs ignored
// [RQ15] write id used only for axi3
// [RQ16] id width one to eight bits
// [RQ17] native controls active high, synchronous
// [RQ18] reinit on rising edge of request
// [RQ19] master waits for ready before traffic
module dsp_subsystem
    import dsp_pkg::*;
(
    // reference clock from the board
    input wire logic pll_ref_clk,
    // axi port and generic signals
    dsp_axi_if.subsystem port,
    // memory alert pin, active low
    input wire logic mem_alert_n
);
    import dsp_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic clk;
    logic rst_n;
    logic [4:0] lock_cnt_reg;
    logic lock_reg;
    logic [5:0] init_cnt_reg;
    logic ready_reg;
    logic reinit_d_reg;
    logic alert_s1_reg;
    logic alert_s2_reg;
    logic alert_status_reg;
    logic [DSP_DATA_W-1:0] mem [DSP_MEM_WORDS];
    logic [DSP_DATA_W-1:0] rdata_reg;
    logic rvalid_reg;
    logic rlast_reg;
    logic [DSP_ID_W-1:0] rid_reg;
    logic w_in_burst;
    logic w_last;
    logic w_resp;
    logic [DSP_ADDR_W-1:0] w_addr;
    logic [DSP_ID_W-1:0] w_id;
    logic r_in_burst;
    logic r_last;
    logic r_resp;
    logic [DSP_ADDR_W-1:0] r_addr;
    logic [DSP_ID_W-1:0] r_id;

    // user clock is the pll output, modelled as a straight feed
    assign clk = pll_ref_clk; // RQ3
    assign port.user_logic_clock = clk; // RQ3
    assign rst_n = port.subsystem_async_reset_n; // RQ4

    ////////////////////////////////////////////////////////////////////////
    // pll lock after a settling count
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_cnt_reg <= 5'h0;
            lock_reg <= 1'b0;
        end
        else if (lock_cnt_reg == 5'(DSP_LOCK_CYCLES))
            lock_reg <= 1'b1; // RQ5
        else
            lock_cnt_reg <= lock_cnt_reg + 5'h1;
    end
    assign port.pll_lock = lock_reg;

    // reinit edge and init/training count up to DSP_INIT_CYCLES
    wire reinit_rise = port.reinit_request && !reinit_d_reg; // RQ18
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reinit_d_reg <= 1'b0;
            init_cnt_reg <= 6'h0;
            ready_reg <= 1'b0;
        end
        else
        begin
            reinit_d_reg <= port.reinit_request;
            if (reinit_rise)
            begin
                init_cnt_reg <= 6'h0; // RQ18
                ready_reg <= 1'b0; // RQ6
            end
            else if (lock_reg && !ready_reg)
            begin
                if (init_cnt_reg == 6'(DSP_INIT_CYCLES))
                    ready_reg <= 1'b1; // RQ6
                else
                    init_cnt_reg <= init_cnt_reg + 6'h1;
            end
        end
    end
    assign port.controller_ready = ready_reg;

    ////////////////////////////////////////////////////////////////////////
    // alert pin synchroniser and sticky status, set beats read clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alert_s1_reg <= 1'b1;
            alert_s2_reg <= 1'b1;
            alert_status_reg <= 1'b0;
        end
        else
        begin
            alert_s1_reg <= mem_alert_n;
            alert_s2_reg <= alert_s1_reg;
            if (!alert_s2_reg)
                alert_status_reg <= 1'b1; // RQ7
            else if (port.ca_parity_status_read)
                alert_status_reg <= 1'b0; // RQ8
        end
    end
    assign port.ca_parity_alert_status = alert_status_reg;

    ////////////////////////////////////////////////////////////////////////
    // write channel; lock, cache and prot never reach any logic (RQ14)
    wire w_fire = port.wvalid && port.wready;
    wire wid_ok = DSP_IS_AXI4 || (port.wid == w_id); // RQ15
    assign port.wready = w_in_burst && wid_ok;
    dsp_burst_engine u_wr (
        .clk(clk),
        .rst_n(rst_n),
        .enable(ready_reg),
        .avalid(port.awvalid),
        .aready(port.awready),
        .aid(port.awid),
        .aaddr(port.awaddr),
        .alen(port.awlen),
        .asize(port.awsize),
        .aburst(port.awburst),
        .beat_fire(w_fire),
        .in_burst(w_in_burst),
        .beat_addr(w_addr),
        .last_beat(w_last),
        .burst_id(w_id),
        .resp_pending(w_resp),
        .resp_fire(port.bvalid && port.bready)
    );
    assign port.bvalid = w_resp;
    assign port.bid = w_id;
    assign port.bresp = DSP_RESP_OKAY;

    // byte-lane write into the word array, one strobe per eight bits (RQ11)
    wire [DSP_MEM_AW-1:0] w_idx = w_addr[DSP_MEM_AW+2:3];
    always_ff @(posedge clk)
    begin
        if (w_fire)
            for (int b = 0; b < DSP_STRB_W; b++)
                if (port.wstrb[b])
                    mem[w_idx][b*8 +: 8] <= port.wdata[b*8 +: 8]; // RQ11
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel with a registered data stage
    wire r_fire = r_in_burst && (!rvalid_reg || port.rready);
    wire [DSP_MEM_AW-1:0] r_idx = r_addr[DSP_MEM_AW+2:3];
    dsp_burst_engine u_rd (
        .clk(clk),
        .rst_n(rst_n),
        .enable(ready_reg),
        .avalid(port.arvalid),
        .aready(port.arready),
        .aid(port.arid),
        .aaddr(port.araddr),
        .alen(port.arlen),
        .asize(port.arsize),
        .aburst(port.arburst),
        .beat_fire(r_fire),
        .in_burst(r_in_burst),
        .beat_addr(r_addr),
        .last_beat(r_last),
        .burst_id(r_id),
        .resp_pending(r_resp),
        .resp_fire(r_resp && (!rvalid_reg || port.rready))
    );
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_reg <= 1'b0;
            rlast_reg <= 1'b0;
            rdata_reg <= '0;
            rid_reg <= '0;
        end
        else if (r_fire)
        begin
            rvalid_reg <= 1'b1; // RQ12
            rlast_reg <= r_last;
            rdata_reg <= mem[r_idx];
            rid_reg <= r_id;
        end
        else if (port.rready)
            rvalid_reg <= 1'b0;
    end
    assign port.rvalid = rvalid_reg;
    assign port.rlast = rlast_reg;
    assign port.rdata = rdata_reg;
    assign port.rid = rid_reg;
    assign port.rresp = DSP_RESP_OKAY;
endmodule

// File: core/dsp_master.sv
// fabric end: apb-driven axi master that waits for the controller
`timescale 1ns/100ps
module dsp_master
    import dsp_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // reset sources
    input wire logic device_init_done,
    input wire logic io_bank_calibrated,
    // axi port
    dsp_axi_if.master port
);
    import dsp_pkg::*;
    logic [31:0] addr_reg;
    logic [DSP_DATA_W-1:0] wdata_reg;
    logic [DSP_DATA_W-1:0] rdata_reg;
    logic [7:0] len_reg;
    logic write_reg;
    logic busy_reg;
    logic aw_reg;
    logic w_reg;
    logic ar_reg;
    logic [7:0] beat_reg;
    logic reinit_reg;
    logic [2:0] irq_reg;
    logic [2:0] mask_reg;
    logic rdy_d_reg;
    logic read_status;

    // subsystem reset from init done and bank calibration
    assign port.subsystem_async_reset_n = device_init_done && io_bank_calibrated; // RQ4

    // apb decode; all accesses answer at once
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire go = wr && paddr == DSP_REG_CTRL && pwdata[DSP_CTRL_GO] && !busy_reg
        && port.controller_ready; // RQ19
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign read_status = rd && paddr == DSP_REG_STATUS;
    assign port.ca_parity_status_read = read_status; // RQ8
    assign irq = |(irq_reg & mask_reg);
    always_comb
    begin
        case (paddr)
            DSP_REG_CTRL: prdata = {30'h0, reinit_reg, write_reg};
            DSP_REG_ADDR: prdata = addr_reg;
            DSP_REG_WDATA: prdata = wdata_reg[31:0];
            DSP_REG_RDATA: prdata = rdata_reg[31:0];
            DSP_REG_STATUS: prdata = {28'h0, port.ca_parity_alert_status, port.pll_lock,
                port.controller_ready, busy_reg};
            DSP_REG_IRQ: prdata = {29'h0, irq_reg};
            DSP_REG_MASK: prdata = {29'h0, mask_reg};
            DSP_REG_LEN: prdata = {24'h0, len_reg};
            default: prdata = DSP_RESET_WORD;
        endcase
    end

    // axi request signals; unsupported attributes driven to zero
    wire done = (port.bvalid && port.bready) || (port.rvalid && port.rready && port.rlast);
    assign port.awvalid = aw_reg; // RQ1
    assign port.awaddr = addr_reg;
    assign port.awid = '0; // RQ16
    assign port.awlen = DSP_LEN_W'(len_reg); // RQ13
    assign port.awsize = 3'h3;
    assign port.awburst = DSP_BURST_INCR;
    assign port.awlock = 2'h0;
    assign port.awcache = 4'h0;
    assign port.awprot = 3'h0;
    assign port.wvalid = w_reg;
    assign port.wdata = wdata_reg;
    assign port.wstrb = '1;
    assign port.wid = '0; // RQ15
    assign port.wlast = (beat_reg == len_reg);
    assign port.bready = 1'b1;
    assign port.arvalid = ar_reg;
    assign port.araddr = addr_reg;
    assign port.arid = '0;
    assign port.arlen = DSP_LEN_W'(len_reg); // RQ13
    assign port.arsize = 3'h3;
    assign port.arburst = DSP_BURST_INCR;
    assign port.arlock = 2'h0;
    assign port.arcache = 4'h0;
    assign port.arprot = 3'h0;
    assign port.rready = 1'b1;
    assign port.reinit_request = reinit_reg; // RQ17

    // register writes and transfer sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_reg <= 32'h0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            len_reg <= 8'h0;
            write_reg <= 1'b0;
            reinit_reg <= 1'b0;
            busy_reg <= 1'b0;
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            ar_reg <= 1'b0;
            beat_reg <= 8'h0;
            irq_reg <= 3'h0;
            mask_reg <= 3'h0;
            rdy_d_reg <= 1'b0;
        end
        else
        begin
            rdy_d_reg <= port.controller_ready;
            if (wr && paddr == DSP_REG_ADDR) addr_reg <= pwdata;
            if (wr && paddr == DSP_REG_WDATA) wdata_reg <= {DSP_DATA_W/32{pwdata}};
            if (wr && paddr == DSP_REG_LEN) len_reg <= pwdata[7:0];
            if (wr && paddr == DSP_REG_MASK) mask_reg <= pwdata[2:0];
            if (wr && paddr == DSP_REG_CTRL)
            begin
                write_reg <= pwdata[DSP_CTRL_WRITE];
                reinit_reg <= pwdata[DSP_CTRL_REINIT];
            end
            if (go)
            begin
                busy_reg <= 1'b1;
                beat_reg <= 8'h0;
                aw_reg <= pwdata[DSP_CTRL_WRITE];
                w_reg <= pwdata[DSP_CTRL_WRITE];
                ar_reg <= !pwdata[DSP_CTRL_WRITE];
            end
            if (port.awvalid && port.awready) aw_reg <= 1'b0;
            if (port.arvalid && port.arready) ar_reg <= 1'b0;
            if (port.wvalid && port.wready)
            begin
                beat_reg <= beat_reg + 8'h1;
                if (port.wlast) w_reg <= 1'b0;
            end
            if (port.rvalid && port.rready) rdata_reg <= port.rdata;
            if (done) busy_reg <= 1'b0;
            // sticky events, set wins over write-one clear
            irq_reg <= (irq_reg & ~((wr && paddr == DSP_REG_IRQ) ? pwdata[2:0] : 3'h0))
                | {port.controller_ready && !rdy_d_reg, port.ca_parity_alert_status, done};
        end
    end
endmodule

// File: testbench/dsp_axi_monitor.sv
// checker on the axi port and generic signals between the two ends
`timescale 1ns/100ps
module dsp_axi_monitor
    import dsp_pkg::*;
(
    // clock and reset
    input wire logic user_logic_clock,
    input wire logic subsystem_async_reset_n,
    // generic status
    input wire logic pll_lock,
    input wire logic controller_ready,
    input wire logic reinit_request,
    // write channels
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic wlast,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    // read channels
    input wire logic [DSP_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [DSP_DATA_W-1:0] rdata
);
    default clocking cb @(posedge user_logic_clock);
    endclocking
    default disable iff (!subsystem_async_reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    // ready, lock and reinit
    property p_ready_lock;
        controller_ready |-> pll_lock;
    endproperty
    a_ready_lock: assert property (p_ready_lock) else $error("ready without lock");
    property p_ready_settle;
        $rose(controller_ready) |-> $past(pll_lock, 32);
    endproperty
    a_ready_settle: assert property (p_ready_settle) else $error("ready rose early");
    property p_reinit_drop;
        $rose(reinit_request) |-> ##[1:2] !controller_ready;
    endproperty
    a_reinit_drop: assert property (p_reinit_drop) else $error("ready kept on reinit");
    property p_aw_gate;
        awready |-> controller_ready;
    endproperty
    a_aw_gate: assert property (p_aw_gate) else $error("address taken while not ready");
    ////////////////////////////////////////////////////////////////////////////////
    // burst handshakes
    property p_ar_hold;
        arvalid && !arready |=> arvalid && $stable(araddr);
    endproperty
    a_ar_hold: assert property (p_ar_hold) else $error("read address dropped");
    property p_b_after_last;
        wvalid && wready && wlast |=> bvalid;
    endproperty
    a_b_after_last: assert property (p_b_after_last) else $error("no write response");
    property p_b_okay;
        bvalid |-> bresp == DSP_RESP_OKAY;
    endproperty
    a_b_okay: assert property (p_b_okay) else $error("write response not okay");
    property p_r_after_ar;
        arvalid && arready |=> ##1 rvalid;
    endproperty
    a_r_after_ar: assert property (p_r_after_ar) else $error("no read data");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule

// File: testbench/tb_top.sv
// bench: both ends joined, driven over apb
`timescale 1ns/100ps
module tb_top;
    import dsp_pkg::*;
    logic ref_clk = 1'b0;
    logic presetn = 1'b0;
    logic boot = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic alert_n = 1'b1;
    logic [31:0] prdata;
    logic pready;
    logic irq;
    logic [31:0] rd;
    wire pclk;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    dsp_axi_if u_if ();
    assign pclk = u_if.user_logic_clock;
    ////////////////////////////////////////////////////////////////////////////////
    // both ends and the checker
    dsp_subsystem u_dsp_subsystem (.pll_ref_clk(ref_clk), .port(u_if.subsystem),
        .mem_alert_n(alert_n));
    dsp_master u_dsp_master (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .irq(irq), .device_init_done(boot), .io_bank_calibrated(boot),
        .port(u_if.master));
    dsp_axi_monitor u_dsp_axi_monitor (.user_logic_clock(u_if.user_logic_clock),
        .subsystem_async_reset_n(u_if.subsystem_async_reset_n), .pll_lock(u_if.pll_lock),
        .controller_ready(u_if.controller_ready), .reinit_request(u_if.reinit_request),
        .awready(u_if.awready), .wvalid(u_if.wvalid), .wready(u_if.wready),
        .wlast(u_if.wlast), .bvalid(u_if.bvalid), .bresp(u_if.bresp), .araddr(u_if.araddr),
        .arvalid(u_if.arvalid), .arready(u_if.arready), .rvalid(u_if.rvalid),
        .rready(u_if.rready), .rdata(u_if.rdata));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            report_and_stop();
        end
    end
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
        tests_run++;
        if (got !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, e, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string name);
        apb(1'b0, a, 32'h0);
        chk(name, e, rd & m);
    endtask
    // poll one status bit until it shows the wanted level
    task automatic poll(input int b, input logic v);
        apb(1'b0, DSP_REG_STATUS, 32'h0);
        while (rd[b] !== v)
        begin
            apb(1'b0, DSP_REG_STATUS, 32'h0);
        end
    endtask
    task automatic report_and_stop;
        $display("counts: %0d compared, %0d mismatched", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial
    begin
        repeat (16) @(posedge ref_clk);
        presetn <= 1'b1;
        boot <= 1'b1;
        poll(1, 1'b1);
        chk("ready", 32'h2, rd & 32'h2);
        chk("lock", 32'h4, rd & 32'h4);
        rchk(DSP_REG_IRQ, 32'h4, 32'h4, "ready irq");
        chk("masked irq", 32'h0, {31'h0, irq});
        $display("test power_up done");
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, DSP_REG_ADDR, i * 32'h40);
            apb(1'b1, DSP_REG_WDATA, 32'h1234_5600 | i);
            apb(1'b1, DSP_REG_LEN, i * 32'h3);
            apb(1'b1, DSP_REG_CTRL, 32'h3);
            poll(0, 1'b0);
        end
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, DSP_REG_ADDR, i * 32'h40);
            apb(1'b1, DSP_REG_LEN, i * 32'h3);
            apb(1'b1, DSP_REG_CTRL, 32'h1);
            poll(0, 1'b0);
            rchk(DSP_REG_RDATA, 32'hffff_ffff, 32'h1234_5600 | i, "read data");
        end
        rchk(DSP_REG_IRQ, 32'h1, 32'h1, "done irq");
        apb(1'b1, DSP_REG_IRQ, 32'h1);
        rchk(DSP_REG_IRQ, 32'h1, 32'h0, "done cleared");
        $display("test bursts done");
        apb(1'b1, DSP_REG_MASK, 32'h2);
        alert_n <= 1'b0;
        repeat (4) @(posedge pclk);
        alert_n <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("alert irq", 32'h1, {31'h0, irq});
        rchk(DSP_REG_STATUS, 32'h8, 32'h8, "parity set");
        rchk(DSP_REG_STATUS, 32'h8, 32'h0, "parity read clear");
        apb(1'b1, DSP_REG_IRQ, 32'h2);
        @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rchk(DSP_REG_MASK, 32'hffff_ffff, 32'h2, "mask");
        $display("test alert done");
        apb(1'b1, DSP_REG_CTRL, 32'h4);
        rchk(DSP_REG_STATUS, 32'h2, 32'h0, "ready on reinit");
        apb(1'b1, DSP_REG_CTRL, 32'h0);
        poll(1, 1'b1);
        chk("ready again", 32'h2, rd & 32'h2);
        rchk(8'h20, 32'hffff_ffff, 32'h0, "unmapped");
        $display("test reinit done");
        report_and_stop();
    end
endmodule
